// [hdl/wdt_defines.svh]
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH
// Notes on behaviour
// - Two independent 32-bit down counters
// - Watchdog reaching zero asserts system reset
// - Watchdog idle after reset until armed
// - Armed watchdog ignores disable and reconfiguration
// - Countdown clock: system clock or 16x baud
// - Watchdog holds count during flash operation
// - Debug halt freezes both counters
// - Service outside window raises an interrupt

// Register indices (printed offsets); byte address is four times index
`define IDX_RELOAD      8'h00
`define IDX_COUNT       8'h04
`define IDX_CONTROL     8'h08
`define IDX_WINDOW      8'h0a
`define IDX_ACK         8'h0c
`define IDX_STATUS      8'h10
`define IDX_MASK        8'h11
`define IDX_CD_RELOAD   8'h12
`define IDX_CD_COUNT    8'h13
`define IDX_CD_CONTROL  8'h14
// Control fields
`define CTL_RUN         0
`define CTL_LOAD        1
`define CTL_CLKSEL      3
`define WIN_SIZE_HI     4
`define WIN_ENABLE      5
// Status / ack bits
`define EV_WINDOW       0
`define EV_COUNTDOWN    1
`define NUM_EVENTS      2
// Reset values
`define RELOAD_RESET    32'hffffffff
`define WINDOW_RESET    5'h1f
`define BAUD_DIV        4'hf
`define SYSRST_CYCLES   4'h8
`endif

// [hdl/wdt_pkg.sv]
package wdt_pkg;
  // Watchdog life cycle
  typedef enum logic [1:0] {
    WD_IDLE  = 2'b00,
    WD_ARMED = 2'b01,
    WD_RESET = 2'b10
  } wd_state_t;
  typedef logic [31:0] count_t;
endpackage : wdt_pkg

// [hdl/count_if.sv]
// Bundle between the top and one down counter
interface count_if;
  logic                 tick;    // Decrement enable
  logic                 load;    // Load reload value
  wdt_pkg::count_t      reload;  // Value to load
  wdt_pkg::count_t      count;   // Present count
  logic                 zero;    // Count is zero
  modport ctl (output tick, output load, output reload, input count, input zero);
  modport cnt (input tick, input load, input reload, output count, output zero);
endinterface : count_if

// [hdl/down_counter.sv]
`include "wdt_defines.svh"
// One 32-bit decrementing counter, stops at zero
module down_counter (
  input  wire logic clk,
  input  wire logic rst_n,
  count_if.cnt      cif
);
  // Count register, starts full
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cif.count <= `RELOAD_RESET;
    end else if (cif.load) begin
      cif.count <= cif.reload;
    end else if (cif.tick && !cif.zero) begin
      cif.count <= cif.count - 32'h00000001;
    end
  end
  assign cif.zero = (cif.count == 32'h00000000);
endmodule : down_counter

// [hdl/baud_tick.sv]
`include "wdt_defines.svh"
// Turns the serial_link 16x baud clock into one system-clock pulse per rising edge.
// Input is a 16x baud clock already; this stage resynchronises it and turns each rising edge into a pulse.
module baud_tick (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic baudIn,
  output logic      tick
);
  logic syncA_q, syncB_q, prev_q;  // Two-stage sync and edge memory
  // Synchroniser; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      syncA_q <= baudIn;
      syncB_q <= syncA_q;
      prev_q  <= syncB_q;
    end
  end
  // One pulse per rising edge of the baud clock
  assign tick = syncB_q & ~prev_q;
endmodule : baud_tick

// [hdl/window_watchdog_and_timer.sv]
// The APB register port was left to the implementer.
`include "wdt_defines.svh"
module window_watchdog_and_timer (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        flashBusy,   // Flash erase/program in progress
  input  wire logic        debugHalt,   // CPU halted by debugger
  input  wire logic        baudX16,     // 16x baud clock of serial_link
  output logic             sysReset,    // System reset request
  output logic             irq          // Level interrupt
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic flashA_q, flashB_q, dbgA_q, dbgB_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flashA_q <= 1'b0;
      flashB_q <= 1'b0;
      dbgA_q   <= 1'b0;
      dbgB_q   <= 1'b0;
    end else begin
      flashA_q <= flashBusy;
      flashB_q <= flashA_q;
      dbgA_q   <= debugHalt;
      dbgB_q   <= dbgA_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  wdt_pkg::wd_state_t wdState_q;           // Watchdog life cycle
  wdt_pkg::count_t    wdReload_q;          // Watchdog reload value
  logic [4:0]         winSize_q;           // Window size
  logic               winEn_q;             // Window check enable
  wdt_pkg::count_t    cdReload_q;          // Countdown reload value
  logic               cdRun_q;             // Countdown running
  logic               cdClkSel_q;          // 1: baud-derived clock
  logic [`NUM_EVENTS-1:0] status_q;        // Sticky events
  logic [`NUM_EVENTS-1:0] mask_q;          // Interrupt enables
  logic [3:0]         rstCnt_q;            // Counts down in the reset state; does not end the reset request
  logic               cdZeroPrev_q;        // Countdown zero edge memory
  logic               cdLoad_q;            // Countdown load request

  // Bus decode: the access phase completes in a single cycle
  logic        wrEn;
  logic [7:0]  idx;
  logic        svcReq;                     // Watchdog service write
  logic        armReq;                     // Watchdog arm write
  assign idx    = paddr[9:2];
  assign wrEn   = psel && penable && pwrite;
  assign armReq = wrEn && (idx == `IDX_CONTROL) && pwdata[`CTL_RUN];
  assign svcReq = wrEn && (idx == `IDX_CONTROL) && pwdata[`CTL_LOAD];

  ////////////////////////////////////////////////////////////////////////
  // Counters
  count_if wdIf ();
  count_if cdIf ();
  logic baudTick;
  logic wdArmed;
  assign wdArmed = (wdState_q == wdt_pkg::WD_ARMED);

  down_counter wdCounter (
    .clk   (clk),
    .rst_n (rst_n),
    .cif   (wdIf)
  );
  down_counter cdCounter (
    .clk   (clk),
    .rst_n (rst_n),
    .cif   (cdIf)
  );
  baud_tick baudGen (
    .clk    (clk),
    .rst_n  (rst_n),
    .baudIn (baudX16),
    .tick   (baudTick)
  );

  // Window open when count has fallen to or below size shifted up
  logic    winOpen;
  logic    goodSvc;
  assign winOpen = !winEn_q || (wdIf.count <= {winSize_q, 27'h0000000});
  assign goodSvc = svcReq && wdArmed && winOpen;

  // Watchdog counter drive
  assign wdIf.tick   = wdArmed && !flashB_q && !dbgB_q;
  assign wdIf.load   = (armReq && (wdState_q == wdt_pkg::WD_IDLE))
                       || goodSvc;
  assign wdIf.reload = wdReload_q;

  // Countdown counter drive, clock base by select
  assign cdIf.tick   = cdRun_q && !dbgB_q
                       && (cdClkSel_q ? baudTick : 1'b1);
  assign cdIf.load   = cdLoad_q;
  assign cdIf.reload = cdReload_q;

  ////////////////////////////////////////////////////////////////////////
  // Watchdog state machine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdState_q <= wdt_pkg::WD_IDLE;
      rstCnt_q  <= 4'h0;
    end else begin
      unique case (wdState_q)
        wdt_pkg::WD_IDLE: begin
          if (armReq) begin
            wdState_q <= wdt_pkg::WD_ARMED;
          end
        end
        wdt_pkg::WD_ARMED: begin
          // No path back to idle: only a system reset disarms it
          if (wdIf.zero && !goodSvc) begin
            wdState_q <= wdt_pkg::WD_RESET;
            rstCnt_q  <= `SYSRST_CYCLES;
          end
        end
        wdt_pkg::WD_RESET: begin
          // Hold the request until the system reset returns
          if (rstCnt_q != 4'h0) begin
            rstCnt_q <= rstCnt_q - 4'h1;
          end
        end
        default: begin
          wdState_q <= wdt_pkg::WD_IDLE;
        end
      endcase
    end
  end

  // System reset output from a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sysReset <= 1'b0;
    end else begin
      sysReset <= (wdState_q == wdt_pkg::WD_RESET);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration writes, locked once armed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdReload_q <= `RELOAD_RESET;
      winSize_q  <= `WINDOW_RESET;
      winEn_q    <= 1'b0;
    end else if (wrEn && (wdState_q == wdt_pkg::WD_IDLE)) begin
      if (idx == `IDX_RELOAD) begin
        wdReload_q <= pwdata;
      end
      if (idx == `IDX_WINDOW) begin
        winSize_q <= pwdata[`WIN_SIZE_HI:0];
        winEn_q   <= pwdata[`WIN_ENABLE];
      end
    end
  end

  // Countdown configuration; never locked
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cdReload_q <= `RELOAD_RESET;
      cdRun_q    <= 1'b0;
      cdClkSel_q <= 1'b0;
      cdLoad_q   <= 1'b0;
      mask_q     <= '0;
    end else begin
      cdLoad_q <= wrEn && (idx == `IDX_CD_CONTROL) && pwdata[`CTL_LOAD];
      if (wrEn && (idx == `IDX_CD_RELOAD)) begin
        cdReload_q <= pwdata;
      end
      if (wrEn && (idx == `IDX_CD_CONTROL)) begin
        cdRun_q    <= pwdata[`CTL_RUN];
        cdClkSel_q <= pwdata[`CTL_CLKSEL];
      end
      if (wrEn && (idx == `IDX_MASK)) begin
        mask_q <= pwdata[`NUM_EVENTS-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky events: set wins over write-one clear
  logic [`NUM_EVENTS-1:0] evSet;
  logic [`NUM_EVENTS-1:0] evClr;
  assign evSet[`EV_WINDOW]    = svcReq && wdArmed && !winOpen;
  assign evSet[`EV_COUNTDOWN] = cdIf.zero && !cdZeroPrev_q && cdRun_q;
  assign evClr = (wrEn && ((idx == `IDX_ACK) || (idx == `IDX_STATUS)))
                 ? pwdata[`NUM_EVENTS-1:0] : '0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q     <= '0;
      cdZeroPrev_q <= 1'b0;
    end else begin
      cdZeroPrev_q <= cdIf.zero;
      status_q     <= (status_q & ~evClr) | evSet;
    end
  end

  // Interrupt output from a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status_q & ~evClr) | evSet) & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data and one-cycle answer; unmapped reads return zero
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h00000000;
    unique case (idx)
      `IDX_RELOAD:     rdMux = wdReload_q;
      `IDX_COUNT:      rdMux = wdIf.count;
      `IDX_CONTROL:    rdMux = {31'h00000000, wdArmed};
      `IDX_WINDOW:     rdMux = {26'h0000000, winEn_q, winSize_q};
      `IDX_STATUS:     rdMux = {30'h00000000, status_q};
      `IDX_MASK:       rdMux = {30'h00000000, mask_q};
      `IDX_CD_RELOAD:  rdMux = cdReload_q;
      `IDX_CD_COUNT:   rdMux = cdIf.count;
      `IDX_CD_CONTROL: rdMux = {28'h0000000, cdClkSel_q, 2'b00, cdRun_q};
      default:         rdMux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;   // Ready in the first access cycle
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite) begin
        prdata <= rdMux;
      end
    end
  end
endmodule : window_watchdog_and_timer

// [bench/wdt_checker.sv]
module wdt_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [31:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        flashBusy,
  input wire logic        debugHalt,
  input wire logic        baudX16,
  input wire logic        sysReset,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic        arm_q;   // Watchdog armed since reset
  logic [31:0] rel_q;   // Reload value as software left it
  logic [1:0]  mask_q;  // Mirror of the mask register
  wire         wrEn = psel && penable && pready && pwrite;
  wire         rdEn = psel && penable && pready && !pwrite;
  ////////////////////////////////////////////////////////////////////////////////
  // Arming is one-way: only a system reset clears it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) arm_q <= 1'b0;
    else if (wrEn && paddr == 32'h20 && pwdata[0]) arm_q <= 1'b1;
  end
  // Reload follows writes only until arming
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rel_q <= 32'hffffffff;
    else if (wrEn && paddr == 32'h00 && !arm_q) rel_q <= pwdata;
  end
  // Mask mirror
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) mask_q <= 2'h0;
    else if (wrEn && paddr == 32'h44) mask_q <= pwdata[1:0];
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Only the slave's answer is checked; the request side belongs to the bench
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_no_error: assert property (pready |-> !pslverr)
    else $error("pslverr raised");
  a_unmapped_zero: assert property (rdEn && paddr == 32'h18 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_reset_holds: assert property (sysReset |=> sysReset)
    else $error("system reset request dropped");
  a_idle_no_reset: assert property (!arm_q |-> !sysReset)
    else $error("system reset without arming");
  a_reload_locked: assert property (rdEn && paddr == 32'h00 |-> prdata == rel_q)
    else $error("reload value changed after arming");
  a_irq_needs_mask: assert property (irq |-> $past(mask_q) != 2'h0)
    else $error("irq with all events masked");
  c_irq: cover property ($rose(irq));
  c_sys_reset: cover property ($rose(sysReset));
  c_locked_write: cover property (arm_q && wrEn && paddr == 32'h00);
endmodule : wdt_checker

bind window_watchdog_and_timer wdt_checker wdt_checker_i (.clk(clk), .rst_n(rst_n),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .flashBusy(flashBusy),
  .debugHalt(debugHalt), .baudX16(baudX16), .sysReset(sysReset), .irq(irq));

// [bench/tb_window_watchdog_and_timer.sv]
module tb_window_watchdog_and_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;       // 20 MHz system clock
  logic        rst_n = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic        flashBusy = 1'b0;
  logic        debugHalt = 1'b0;
  logic        baudX16 = 1'b0;  // Held still except when ticks are wanted
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sysReset;
  logic        irq;
  int          errorCnt = 0;
  int          samplesChecked = 0;
  int          cycles = 0;
  logic [31:0] valA;
  logic [31:0] valB;
  logic [31:0] valC;             // Watchdog count just before a bad service
  always #25 clk = ~clk;
  window_watchdog_and_timer window_watchdog_and_timer_i (.clk(clk), .rst_n(rst_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .flashBusy(flashBusy),
    .debugHalt(debugHalt), .baudX16(baudX16), .sysReset(sysReset), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task endSim;
    if (errorCnt == 0 && samplesChecked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : endSim
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errorCnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One APB transfer; an idle cycle follows so psel is never driven twice at once
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d,
           output logic [31:0] r);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, valB);
  endtask : wr
  task rd(input string what, input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, valB);
    check(what, valB, exp);
  endtask : rd
  // Bounded wait for the interrupt line
  task waitIrq;
    repeat (100) if (irq !== 1'b1) @(posedge clk);
    check("irq", {31'h0, irq}, 32'h1);
  endtask : waitIrq
  // Hang guard: whole run is well under 2000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errorCnt++;
      endSim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd("reload", 32'h00, 32'hffffffff);
    rd("count idle", 32'h10, 32'hffffffff);
    rd("window", 32'h28, 32'h1f);
    rd("cd count", 32'h4c, 32'hffffffff);
    rd("unmapped", 32'h18, 32'h0);
    wr(32'h44, 32'h3);
    rd("mask", 32'h44, 32'h3);
    // Countdown on the system clock, frozen by debug halt
    wr(32'h48, 32'd40);
    wr(32'h50, 32'h2);
    wr(32'h50, 32'h1);
    debugHalt <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, 32'h4c, 32'h0, valA);
    repeat (6) @(posedge clk);
    rd("cd halted", 32'h4c, valA);
    debugHalt <= 1'b0;
    waitIrq();
    wr(32'h50, 32'h0);
    rd("cd zero", 32'h4c, 32'h0);
    rd("status cd", 32'h40, 32'h2);
    wr(32'h30, 32'h2);
    rd("status clr", 32'h40, 32'h0);
    check("irq clr", {31'h0, irq}, 32'h0);
    // Countdown on baud ticks: still without them, three ticks reach zero
    wr(32'h48, 32'd3);
    wr(32'h50, 32'h2);
    wr(32'h50, 32'h9);
    rd("cd ctl", 32'h50, 32'h9);
    repeat (20) @(posedge clk);
    rd("cd no tick", 32'h4c, 32'd3);
    repeat (3) begin
      baudX16 <= 1'b1;
      repeat (4) @(posedge clk);
      baudX16 <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    rd("cd ticks", 32'h4c, 32'h0);
    rd("status tick", 32'h40, 32'h2);
    wr(32'h50, 32'h0);
    // Clear through the status address this time
    wr(32'h40, 32'h2);
    // Watchdog: window opens 0x100 counts after arming
    wr(32'h00, 32'hf8000100);
    wr(32'h28, 32'h3f);
    wr(32'h20, 32'h1);
    rd("armed", 32'h20, 32'h1);
    wr(32'h00, 32'h5);
    rd("reload lock", 32'h00, 32'hf8000100);
    wr(32'h28, 32'h0);
    rd("window lock", 32'h28, 32'h3f);
    // Let the count fall well below a fresh reload before the bad service
    repeat (40) @(posedge clk);
    apb(1'b0, 32'h10, 32'h0, valC);
    wr(32'h20, 32'h2);
    waitIrq();
    rd("status win", 32'h40, 32'h1);
    wr(32'h30, 32'h1);
    flashBusy <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, 32'h10, 32'h0, valA);
    repeat (6) @(posedge clk);
    rd("wd flash", 32'h10, valA);
    // A service outside the window must not reload: the count kept falling
    check("early no reload", {31'h0, valA < valC}, 32'h1);
    flashBusy <= 1'b0;
    // Debug halt freezes the watchdog too
    debugHalt <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, 32'h10, 32'h0, valA);
    repeat (6) @(posedge clk);
    rd("wd halted", 32'h10, valA);
    debugHalt <= 1'b0;
    repeat (300) @(posedge clk);
    wr(32'h20, 32'h2);
    apb(1'b0, 32'h10, 32'h0, valA);
    check("wd reloaded", {31'h0, valA > 32'hf8000000}, 32'h1);
    rd("status ok", 32'h40, 32'h0);
    // Second reset, then a short watchdog runs out
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check("sysreset off", {31'h0, sysReset}, 32'h0);
    rst_n <= 1'b1;
    @(posedge clk);
    // Unmask all events so a wrong interrupt on expiry would show
    wr(32'h44, 32'h3);
    wr(32'h00, 32'd30);
    wr(32'h20, 32'h1);
    repeat (100) if (sysReset !== 1'b1) @(posedge clk);
    check("sysreset", {31'h0, sysReset}, 32'h1);
    check("no irq", {31'h0, irq}, 32'h0);
    endSim();
  end
endmodule : tb_window_watchdog_and_timer
